// File: hdl/dtc_pkg.sv
// Shared constants for the dual timer with capture and reload.
package dtc_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned TMR_W = 16;
  // Register byte offsets.
  localparam logic [7:0] OFS_AUX_CTRL = 8'h00;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h04;
  localparam logic [7:0] OFS_AUX_TIMER = 8'h08;
  localparam logic [7:0] OFS_CORE_TIMER = 8'h0c;
  localparam logic [7:0] OFS_CAPTURE_RELOAD_REG = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // Timer control field positions.
  localparam int unsigned CTL_RUN = 0;
  localparam int unsigned CTL_DOWN = 1;
  localparam int unsigned CTL_EXT_DIR = 2;
  localparam int unsigned CTL_SRC_LO = 3;
  localparam int unsigned CTL_SRC_HI = 4;
  localparam int unsigned CTL_PRE_LO = 5;
  localparam int unsigned CTL_PRE_HI = 7;
  localparam int unsigned CTL_EDGE_LO = 8;
  localparam int unsigned CTL_EDGE_HI = 9;
  localparam int unsigned CTL_OUT_EN = 10;
  localparam int unsigned CTL_RELOAD = 11;
  localparam int unsigned CTL_CLR_CAP = 12;
  localparam int unsigned CTL_CAP_LO = 13;
  localparam int unsigned CTL_CAP_HI = 14;
  localparam int unsigned CTL_CAP_CNT_IN = 15;
  localparam int unsigned CTL_CAP_DIR_IN = 16;
  localparam int unsigned CTL_W = 17;
  localparam logic [CTL_W-1:0] CTL_RESET = 17'h00000;
  // Count source selection.
  localparam logic [1:0] SRC_PRESCALE = 2'h0;
  localparam logic [1:0] SRC_EXT_PIN = 2'h1;
  localparam logic [1:0] SRC_TOGGLE = 2'h2;
  // Interrupt status bits.
  localparam int unsigned IRQ_AUX_WRAP = 0;
  localparam int unsigned IRQ_CORE_WRAP = 1;
  localparam int unsigned IRQ_CAPTURE = 2;
  localparam int unsigned IRQ_W = 3;
  // Finest count granularity in system clocks.
  localparam int unsigned MIN_TICK_CYCLES = 2;
  localparam int unsigned PRE_W = 10;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : dtc_pkg

// File: hdl/dtc_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
module dtc_sync (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic din, // Asynchronous pin.
  output logic dout // Filtered level.
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } dtc_sync_state_t;
  dtc_sync_state_t st;
  dtc_sync_state_t next_st;

  // The first stage feeds only the second; the level moves once stages two and three agree.
  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.q = st.s3;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.q;
endmodule // dtc_sync
`default_nettype wire

// File: hdl/dtc_timer.sv
// One 16-bit up/down timer with prescaler, source and direction selection.
`timescale 1ns/1ps
`default_nettype none
module dtc_timer #(
  parameter int unsigned WIDTH = 16 // Timer width.
) (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [dtc_pkg::CTL_W-1:0] ctrl, // Control word.
  input wire logic ext_cnt, // Synchronised external count level.
  input wire logic ext_dir, // Synchronised external direction level.
  input wire logic toggle_cnt, // Toggle latch level used as clock.
  input wire logic load, // Load strobe, wins over counting.
  input wire logic [WIDTH-1:0] load_val, // Value to load.
  output logic [WIDTH-1:0] count, // Current timer value.
  output logic wrap // One-cycle pulse on overflow or underflow.
);
  typedef struct packed {
    logic [dtc_pkg::PRE_W-1:0] pre;
    logic [WIDTH-1:0] cnt;
    logic ext_q;
    logic tog_q;
    logic wrap;
  } dtc_timer_state_t;
  dtc_timer_state_t st;
  dtc_timer_state_t next_st;
  logic [2:0] pre_sel;
  logic [1:0] src;
  logic [1:0] edge_sel;
  logic down;
  logic tick;
  logic ext_rise;
  logic ext_fall;
  logic [dtc_pkg::PRE_W-1:0] pre_term;

  initial begin
    if (WIDTH < 2) begin
      $error("dtc_timer width too small");
    end
  end

  assign pre_sel = ctrl[dtc_pkg::CTL_PRE_HI:dtc_pkg::CTL_PRE_LO];
  assign src = ctrl[dtc_pkg::CTL_SRC_HI:dtc_pkg::CTL_SRC_LO];
  assign edge_sel = ctrl[dtc_pkg::CTL_EDGE_HI:dtc_pkg::CTL_EDGE_LO];
  // Software direction, or the external level when selected.
  assign down = ctrl[dtc_pkg::CTL_EXT_DIR] ? ext_dir : ctrl[dtc_pkg::CTL_DOWN];
  assign ext_rise = ext_cnt && !st.ext_q;
  assign ext_fall = !ext_cnt && st.ext_q;
  // Prescaler period is MIN_TICK_CYCLES shifted by the selection, never finer.
  assign pre_term = dtc_pkg::PRE_W'((dtc_pkg::MIN_TICK_CYCLES << pre_sel) - 1);

  // Count tick from the selected source.
  always_comb begin
    tick = 1'b0;
    case (src)
      dtc_pkg::SRC_PRESCALE: tick = (st.pre == pre_term);
      dtc_pkg::SRC_EXT_PIN: tick = (edge_sel[0] && ext_rise) || (edge_sel[1] && ext_fall);
      dtc_pkg::SRC_TOGGLE: tick = toggle_cnt != st.tog_q;
      default: tick = 1'b0;
    endcase
    tick = tick && ctrl[dtc_pkg::CTL_RUN];
  end

  // Next state: prescaler, edge history, count and wrap pulse.
  always_comb begin
    next_st = st;
    next_st.ext_q = ext_cnt;
    next_st.tog_q = toggle_cnt;
    next_st.wrap = 1'b0;
    if (!ctrl[dtc_pkg::CTL_RUN] || st.pre == pre_term) begin
      next_st.pre = '0;
    end else begin
      next_st.pre = st.pre + 1'b1;
    end
    if (load) begin
      next_st.cnt = load_val;
    end else if (tick) begin
      if (down) begin
        next_st.cnt = st.cnt - 1'b1;
        next_st.wrap = (st.cnt == '0);
      end else begin
        next_st.cnt = st.cnt + 1'b1;
        next_st.wrap = (st.cnt == '1);
      end
      // A reload replaces the wrapped value on the wrapping tick itself.
      if (next_st.wrap && ctrl[dtc_pkg::CTL_RELOAD]) begin
        next_st.cnt = load_val;
      end
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.cnt;
  assign wrap = st.wrap;
endmodule // dtc_timer
`default_nettype wire

// File: hdl/dtc_top.sv
// Dual timer with shared capture/reload register and AXI4-Lite register access.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Timers advance at most every two clocks.
// - Each timer counts prescaled clock or pin events.
// - Direction from software or external level.
// - Auxiliary direction input is internal only.
// - Toggle latch inverts on every core wrap.
// - Latch clocks auxiliary timer; drives toggle pin.
// - Core wraps offered to capture/compare unit.
// - Core wrap may trigger capture register reload.
// - Capture pin edge copies auxiliary timer.
// - Optional clear of auxiliary timer after capture.
// - First module inputs may trigger capture.
// - Timers and capture register are 16 bits.
module dtc_top #(
  parameter int unsigned TMR_W = dtc_pkg::TMR_W // Timer width.
) (
  input wire logic aclk, // System clock, 40 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic aux_count_pin, // Auxiliary timer external count pin.
  input wire logic core_count_pin, // Core timer external count pin.
  input wire logic core_direction_input, // Core timer external direction pin.
  input wire logic capture_input_pin, // Capture trigger pin.
  input wire logic first_module_count_input, // First module core timer count pin.
  input wire logic first_module_direction_input, // First module core timer direction pin.
  output logic toggle_output_pin, // Toggle latch output.
  output logic core_wrap_event, // Pulse to the capture/compare unit timers.
  output logic irq // Level interrupt.
);
  typedef struct packed {
    logic [dtc_pkg::CTL_W-1:0] aux_ctrl;
    logic [dtc_pkg::CTL_W-1:0] core_ctrl;
    logic [TMR_W-1:0] capture_reload_reg;
    logic core_toggle_latch;
    logic [dtc_pkg::IRQ_W-1:0] irq_status;
    logic [dtc_pkg::IRQ_W-1:0] irq_mask;
    logic cap_q;
    logic fm_cnt_q;
    logic fm_dir_q;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic out_pin;
  } dtc_top_state_t;
  dtc_top_state_t st;
  dtc_top_state_t next_st;

  logic aux_cnt_s;
  logic core_cnt_s;
  logic core_dir_s;
  logic cap_s;
  logic fm_cnt_s;
  logic fm_dir_s;
  logic [TMR_W-1:0] aux_count;
  logic [TMR_W-1:0] core_count;
  logic aux_wrap;
  logic core_wrap;
  logic aux_load;
  logic [TMR_W-1:0] aux_load_val;
  logic core_load;
  logic [TMR_W-1:0] core_load_val;
  logic capture;
  logic [dtc_pkg::CTL_W-1:0] aux_ctrl_eff;
  logic wr_go;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic [1:0] rd_resp;
  logic [5:0] pin_in;
  logic [5:0] pin_sync;
  logic [dtc_pkg::IRQ_W-1:0] irq_set;

  initial begin
    if (TMR_W != dtc_pkg::TMR_W) begin
      $error("dtc_top timer width must be 16");
    end
  end

  // Every pin passes the three-stage synchroniser.
  assign pin_in = {first_module_direction_input, first_module_count_input, capture_input_pin,
    core_direction_input, core_count_pin, aux_count_pin};
  generate
    for (genvar i = 0; i < 6; i++) begin : g_sync
      dtc_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din(pin_in[i]),
        .dout(pin_sync[i])
      );
    end
  endgenerate
  assign aux_cnt_s = pin_sync[0];
  assign core_cnt_s = pin_sync[1];
  assign core_dir_s = pin_sync[2];
  assign cap_s = pin_sync[3];
  assign fm_cnt_s = pin_sync[4];
  assign fm_dir_s = pin_sync[5];

  // Capture on selected capture pin edges, or on any edge of a first module input enabled by CTL_CAP_CNT_IN or CTL_CAP_DIR_IN.
  always_comb begin
    capture = 1'b0;
    if (st.aux_ctrl[dtc_pkg::CTL_CAP_LO] && cap_s && !st.cap_q) begin
      capture = 1'b1;
    end
    if (st.aux_ctrl[dtc_pkg::CTL_CAP_HI] && !cap_s && st.cap_q) begin
      capture = 1'b1;
    end
    if (st.aux_ctrl[dtc_pkg::CTL_CAP_CNT_IN] && (fm_cnt_s != st.fm_cnt_q)) begin
      capture = 1'b1;
    end
    if (st.aux_ctrl[dtc_pkg::CTL_CAP_DIR_IN] && (fm_dir_s != st.fm_dir_q)) begin
      capture = 1'b1;
    end
  end

  // Clear after capture; it beats a software write of the timer.
  assign aux_load = capture && st.aux_ctrl[dtc_pkg::CTL_CLR_CAP];
  assign aux_load_val = '0;

  // Reload on wrap belongs to the core timer alone.
  always_comb begin
    aux_ctrl_eff = st.aux_ctrl;
    aux_ctrl_eff[dtc_pkg::CTL_RELOAD] = 1'b0;
  end

  // The auxiliary direction is only internal: its external level is tied low.
  dtc_timer #(.WIDTH(TMR_W)) u_aux (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctrl(aux_ctrl_eff),
    .ext_cnt(aux_cnt_s),
    .ext_dir(1'b0),
    .toggle_cnt(st.core_toggle_latch),
    .load(aux_load || (wr_go && st.aw_addr == dtc_pkg::OFS_AUX_TIMER)),
    .load_val(aux_load ? aux_load_val : wr_val[TMR_W-1:0]),
    .count(aux_count),
    .wrap(aux_wrap)
  );

  // Core timer; outside a write it is offered the reload value, which it takes on the
  // wrapping tick itself, so the wrapped value never stands.
  assign core_load = wr_go && st.aw_addr == dtc_pkg::OFS_CORE_TIMER;
  assign core_load_val = core_load ? wr_val[TMR_W-1:0] : st.capture_reload_reg;
  dtc_timer #(.WIDTH(TMR_W)) u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .ctrl(st.core_ctrl),
    .ext_cnt(core_cnt_s),
    .ext_dir(core_dir_s),
    .toggle_cnt(1'b0),
    .load(core_load),
    .load_val(core_load_val),
    .count(core_count),
    .wrap(core_wrap)
  );

  // Write takes place once both address and data are held.
  assign wr_go = st.aw_full && st.w_full && !st.bvalid;
  always_comb begin
    wr_val = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      if (st.w_strb[b]) begin
        wr_val[8*b +: 8] = st.w_data[8*b +: 8];
      end
    end
  end

  // Read multiplexer with error answer for unmapped offsets.
  always_comb begin
    rd_val = 32'h00000000;
    rd_resp = dtc_pkg::RESP_OKAY;
    case (s_axi_araddr)
      dtc_pkg::OFS_AUX_CTRL: rd_val[dtc_pkg::CTL_W-1:0] = st.aux_ctrl;
      dtc_pkg::OFS_CORE_CTRL: rd_val[dtc_pkg::CTL_W-1:0] = st.core_ctrl;
      dtc_pkg::OFS_AUX_TIMER: rd_val[TMR_W-1:0] = aux_count;
      dtc_pkg::OFS_CORE_TIMER: rd_val[TMR_W-1:0] = core_count;
      dtc_pkg::OFS_CAPTURE_RELOAD_REG: rd_val[TMR_W-1:0] = st.capture_reload_reg;
      dtc_pkg::OFS_IRQ_STATUS: rd_val[dtc_pkg::IRQ_W-1:0] = st.irq_status;
      dtc_pkg::OFS_IRQ_MASK: rd_val[dtc_pkg::IRQ_W-1:0] = st.irq_mask;
      default: rd_resp = dtc_pkg::RESP_SLVERR;
    endcase
  end

  assign irq_set = {capture, core_wrap, aux_wrap};

  // Register file, bus handshakes and toggle latch.
  always_comb begin
    next_st = st;
    next_st.cap_q = cap_s;
    next_st.fm_cnt_q = fm_cnt_s;
    next_st.fm_dir_q = fm_dir_s;
    if (core_wrap) begin
      next_st.core_toggle_latch = !st.core_toggle_latch;
    end
    next_st.out_pin = st.core_toggle_latch && st.core_ctrl[dtc_pkg::CTL_OUT_EN];
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = dtc_pkg::RESP_OKAY;
      case (st.aw_addr)
        dtc_pkg::OFS_AUX_CTRL: next_st.aux_ctrl = wr_val[dtc_pkg::CTL_W-1:0];
        dtc_pkg::OFS_CORE_CTRL: next_st.core_ctrl = wr_val[dtc_pkg::CTL_W-1:0];
        dtc_pkg::OFS_CAPTURE_RELOAD_REG: next_st.capture_reload_reg = wr_val[TMR_W-1:0];
        dtc_pkg::OFS_IRQ_STATUS: next_st.irq_status = st.irq_status & ~wr_val[dtc_pkg::IRQ_W-1:0];
        dtc_pkg::OFS_IRQ_MASK: next_st.irq_mask = wr_val[dtc_pkg::IRQ_W-1:0];
        dtc_pkg::OFS_AUX_TIMER: next_st.bresp = dtc_pkg::RESP_OKAY;
        dtc_pkg::OFS_CORE_TIMER: next_st.bresp = dtc_pkg::RESP_OKAY;
        default: next_st.bresp = dtc_pkg::RESP_SLVERR;
      endcase
    end
    // Capture beats a simultaneous software write of the register.
    if (capture) begin
      next_st.capture_reload_reg = aux_count;
    end
    // Hardware set wins over a write-one clear in the same cycle.
    next_st.irq_status = next_st.irq_status | irq_set;
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_val;
      next_st.rresp = rd_resp;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.aux_ctrl <= dtc_pkg::CTL_RESET;
      st.core_ctrl <= dtc_pkg::CTL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // One address and one data word are held at a time; reads answer the cycle after.
  assign s_axi_awready = !st.aw_full;
  assign s_axi_wready = !st.w_full;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign toggle_output_pin = st.out_pin;
  assign core_wrap_event = core_wrap;
  assign irq = |(st.irq_status & st.irq_mask);
endmodule // dtc_top
`default_nettype wire

// File: sim/dtc_top_sva.sv
// Checker of the register bus and event outputs of the dual timer.
`timescale 1ns/1ps
`default_nettype none
module dtc_top_sva #(
  parameter int unsigned TMR_W = 16 // Timer width.
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset.
  input wire logic [7:0] s_axi_awaddr, // Bus.
  input wire logic s_axi_awvalid, // Bus.
  input wire logic s_axi_awready, // Bus.
  input wire logic s_axi_wvalid, // Bus.
  input wire logic s_axi_wready, // Bus.
  input wire logic [1:0] s_axi_bresp, // Bus.
  input wire logic s_axi_bvalid, // Bus.
  input wire logic s_axi_bready, // Bus.
  input wire logic [7:0] s_axi_araddr, // Bus.
  input wire logic s_axi_arvalid, // Bus.
  input wire logic s_axi_arready, // Bus.
  input wire logic [31:0] s_axi_rdata, // Bus.
  input wire logic s_axi_rvalid, // Bus.
  input wire logic s_axi_rready, // Bus.
  input wire logic toggle_output_pin, // Latch pin.
  input wire logic core_wrap_event // Wrap pulse.
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] last_ar;
  // The read address is kept so the width of the answer can be judged.
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      last_ar <= s_axi_araddr;
    end
  end
  property p_wrap_pulse;
    core_wrap_event |=> !core_wrap_event;
  endproperty
  a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap pulse too long");
  // The pin may also move when software rewrites its enable.
  property p_toggle_cause;
    $changed(toggle_output_pin) |-> core_wrap_event || $past(core_wrap_event)
      || $past(core_wrap_event, 2) || s_axi_bvalid || $past(s_axi_bvalid)
      || $past(s_axi_bvalid, 2);
  endproperty
  a_toggle_cause: assert property (p_toggle_cause) else $error("toggle without wrap");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_ar_ready;
    s_axi_arready == !s_axi_rvalid;
  endproperty
  a_ar_ready: assert property (p_ar_ready) else $error("read address ready wrong");
  // The answer stands two edges after both halves are taken together.
  property p_w_ok;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr <= 8'h18
      && s_axi_awaddr[1:0] == 2'h0 |-> ##2 s_axi_bvalid && s_axi_bresp == dtc_pkg::RESP_OKAY;
  endproperty
  a_w_ok: assert property (p_w_ok) else $error("mapped write not okay");
  property p_w_err;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr > 8'h18
      |-> ##2 s_axi_bvalid && s_axi_bresp == dtc_pkg::RESP_SLVERR;
  endproperty
  a_w_err: assert property (p_w_err) else $error("unmapped write accepted");
  property p_r_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_width;
    s_axi_rvalid && last_ar inside {8'h08, 8'h0c, 8'h10} |-> s_axi_rdata[31:TMR_W] == '0;
  endproperty
  a_width: assert property (p_width) else $error("timer wider than allowed");
endmodule // dtc_top_sva
bind dtc_top dtc_top_sva #(.TMR_W(TMR_W)) u_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .toggle_output_pin(toggle_output_pin), .core_wrap_event(core_wrap_event));
`default_nettype wire

// File: sim/dtc_pin_model.sv
// Model of the pins and sibling timer inputs facing the dual timer.
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
  input wire logic aclk, // Paces pin changes.
  input wire logic aresetn, // Returns pins low.
  input wire logic [5:0] flip, // Requests to invert a pin.
  output logic [5:0] pins // Pin levels.
);
  logic [5:0] lvl;
  // Each request inverts one level, so rising and falling edges come from one path.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl <= 6'h00;
    end else begin
      lvl <= lvl ^ flip;
    end
  end
  assign pins = lvl;
endmodule // dtc_pin_model
`default_nettype wire

// File: sim/dual_timer_capture_reload_tb.sv
// Self-checking bench of the dual timer with capture and reload.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_capture_reload_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic toggle_output_pin, core_wrap_event, irq;
  logic [5:0] flip = 6'h00;
  wire logic [5:0] pins;
  int n_errors = 0, num_checks = 0, cyc = 0;
  logic [31:0] seed = 32'd75;
  always #12.5 aclk = ~aclk;
  dtc_pin_model u_pins (.aclk(aclk), .aresetn(aresetn), .flip(flip), .pins(pins));
  dtc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .aux_count_pin(pins[3]), .core_count_pin(pins[4]),
    .core_direction_input(pins[5]), .capture_input_pin(pins[0]),
    .first_module_count_input(pins[1]), .first_module_direction_input(pins[2]),
    .toggle_output_pin(toggle_output_pin), .core_wrap_event(core_wrap_event), .irq(irq));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic conclude(input bit hung);
    if (hung) n_errors++;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // The whole run needs about a thousand cycles; a hang stops far above that.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) conclude(1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Address and data are offered together and each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk(s_axi_rresp, er);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d, dtc_pkg::RESP_OKAY);
    chk(d, e);
  endtask
  task automatic ok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, dtc_pkg::RESP_OKAY);
  endtask
  // Waits for a core wrap and returns the cycle it was seen in.
  task automatic ww(output int t);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!core_wrap_event && n < 1000);
    t = cyc;
  endtask
  // Pin changes are spaced widely enough for the input synchronisers.
  task automatic tog(input int i);
    @(posedge aclk);
    flip <= 6'h01 << i;
    @(posedge aclk);
    flip <= 6'h00;
    repeat (6) @(posedge aclk);
  endtask
  initial begin
    logic [31:0] v, w, c;
    int t0, t1, s, e;
    logic p0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values, width of a timer and an unmapped place.
    rc(dtc_pkg::OFS_CORE_CTRL, 32'h0);
    rc(dtc_pkg::OFS_IRQ_MASK, 32'h0);
    v = xs();
    ok(dtc_pkg::OFS_AUX_TIMER, v);
    rc(dtc_pkg::OFS_AUX_TIMER, {16'h0, v[15:0]});
    wr(8'h1c, v, dtc_pkg::RESP_SLVERR);
    rd(8'h1c, w, dtc_pkg::RESP_SLVERR);
    // Pin counting on both timers with only rising edges chosen.
    for (int k = 0; k < 2; k++) begin
      ok(k ? dtc_pkg::OFS_CORE_TIMER : dtc_pkg::OFS_AUX_TIMER, 32'h0);
      ok(k ? dtc_pkg::OFS_CORE_CTRL : dtc_pkg::OFS_AUX_CTRL, 32'h0109);
      for (int j = 0; j < 10; j++) tog(3 + k);
      rc(k ? dtc_pkg::OFS_CORE_TIMER : dtc_pkg::OFS_AUX_TIMER, 32'h5);
      ok(k ? dtc_pkg::OFS_CORE_CTRL : dtc_pkg::OFS_AUX_CTRL, 32'h0);
    end
    // Reload periods: finest prescale, a random one, then down by the direction pin.
    s = int'(xs() % 32'h3);
    for (int m = 0; m < 3; m++) begin
      w = (m == 2) ? 32'h0010 : 32'hfff0;
      c = (m == 2) ? 32'h0c05 : (32'h0c01 | ((m == 1 ? s : 0) << 5));
      e = (m == 2 ? 17 : 16) * (2 << (m == 1 ? s : 0));
      ok(dtc_pkg::OFS_CAPTURE_RELOAD_REG, w);
      ok(dtc_pkg::OFS_CORE_TIMER, w);
      if (m == 2) tog(5);
      ok(dtc_pkg::OFS_CORE_CTRL, c);
      ww(t0);
      ww(t0);
      repeat (4) @(posedge aclk);
      p0 = toggle_output_pin;
      ww(t1);
      chk(32'(t1 - t0), 32'(e));
      repeat (4) @(posedge aclk);
      chk({31'h0, toggle_output_pin}, {31'h0, !p0});
    end
    // The latch clocks the auxiliary timer, which ignores the direction pin, still high.
    ok(dtc_pkg::OFS_AUX_TIMER, 32'h0);
    ww(t0);
    repeat (4) @(posedge aclk);
    ok(dtc_pkg::OFS_AUX_CTRL, 32'h0015);
    for (int j = 0; j < 4; j++) ww(t0);
    repeat (4) @(posedge aclk);
    ok(dtc_pkg::OFS_CORE_CTRL, 32'h0);
    rc(dtc_pkg::OFS_AUX_TIMER, 32'h4);
    rc(dtc_pkg::OFS_IRQ_STATUS, 32'h2);
    ok(dtc_pkg::OFS_AUX_CTRL, 32'h0);
    // Capture from the capture pin with clearing, then from the first module's inputs.
    for (int i = 0; i < 3; i++) begin
      v = (xs() & 32'hffff) | 32'h1;
      ok(dtc_pkg::OFS_AUX_TIMER, v);
      ok(dtc_pkg::OFS_IRQ_STATUS, 32'h7);
      ok(dtc_pkg::OFS_AUX_CTRL, i == 0 ? 32'h3000 : (32'h4000 << i));
      tog(i);
      rc(dtc_pkg::OFS_CAPTURE_RELOAD_REG, v);
      rc(dtc_pkg::OFS_AUX_TIMER, i == 0 ? 32'h0 : v);
      rc(dtc_pkg::OFS_IRQ_STATUS, 32'h4);
    end
    // A falling capture pin edge is ignored when only rising is chosen.
    ok(dtc_pkg::OFS_AUX_TIMER, ~v & 32'hffff);
    ok(dtc_pkg::OFS_AUX_CTRL, 32'h2000);
    tog(0);
    rc(dtc_pkg::OFS_CAPTURE_RELOAD_REG, v);
    // The interrupt follows the mask and is cleared by writing a one.
    chk({31'h0, irq}, 32'h0);
    ok(dtc_pkg::OFS_IRQ_MASK, 32'h4);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    ok(dtc_pkg::OFS_IRQ_STATUS, 32'h4);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rc(dtc_pkg::OFS_IRQ_STATUS, 32'h0);
    conclude(1'b0);
  end
endmodule // dual_timer_capture_reload_tb
`default_nettype wire
